//--- shared/psw_flag_pkg.sv
package psw_flag_pkg;

  // Status word layout
  localparam int          PSW_W        = 32;
  localparam int          ZERO_POS     = 0;
  localparam int          SIGN_POS     = 1;
  localparam int          WRAP_POS     = 2;
  localparam int          CARRY_POS    = 3;
  localparam int          CLAMP_POS    = 4;
  localparam int          MASK_POS     = 5;
  localparam int          EXC_POS      = 6;
  localparam logic [31:0] PSW_RESET    = 32'h0000_0020;
  localparam logic [31:0] PSW_WR_MASK  = 32'h0000_007F;

  // Saturation limits
  localparam logic [31:0] CLAMP_MAX    = 32'h7FFF_FFFF;
  localparam logic [31:0] CLAMP_MIN    = 32'h8000_0000;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_ADD      = 3'h0,
    OP_SUB      = 3'h1,
    OP_CMP      = 3'h2,
    OP_AND      = 3'h3,
    OP_OR       = 3'h4,
    OP_XOR      = 3'h5,
    OP_CLAMPADD = 3'h6,
    OP_CLAMPSUB = 3'h7
  } alu_op_t;

  typedef struct packed {
    logic        valid;
    alu_op_t     op;
    logic [31:0] a;
    logic [31:0] b;
  } alu_req_t;

  typedef struct packed {
    logic zero;
    logic sign;
    logic wrap;
    logic carry;
    logic carry_we;
    logic clamp_set;
    logic write_back;
  } flag_upd_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_ACK  = 2'b01,
    IRQ_HOLD = 2'b11
  } irq_state_t;

endpackage

//--- rtl/flag_calc.sv
`timescale 1ns/10ps
module flag_calc
  import psw_flag_pkg::*;
(
  // Operation in
  input  alu_req_t    req,
  // Result and flags out
  output logic [31:0] result,
  output flag_upd_t   upd
);

  logic [32:0] sum_w;
  logic [32:0] diff_w;
  logic        add_ovf;
  logic        sub_ovf;
  logic        is_sub;
  logic        ovf;
  logic [31:0] raw;

  assign sum_w   = {1'b0, req.a} + {1'b0, req.b};
  assign diff_w  = {1'b0, req.a} - {1'b0, req.b};
  assign add_ovf = (req.a[31] == req.b[31]) && (sum_w[31] != req.a[31]);
  assign sub_ovf = (req.a[31] != req.b[31]) && (diff_w[31] != req.a[31]);
  assign is_sub  = (req.op == OP_SUB) || (req.op == OP_CMP) ||
                   (req.op == OP_CLAMPSUB);
  assign ovf     = is_sub ? sub_ovf : add_ovf;

  always_comb
  begin
    raw            = sum_w[31:0];
    upd.carry      = 1'b0;
    upd.carry_we   = 1'b1;
    upd.wrap       = 1'b0;
    upd.clamp_set  = 1'b0;
    upd.write_back = (req.op != OP_CMP);
    case (req.op)
      OP_ADD, OP_CLAMPADD:
      begin
        raw       = sum_w[31:0];
        upd.carry = sum_w[32];
        upd.wrap  = ovf;
      end
      OP_SUB, OP_CMP, OP_CLAMPSUB:
      begin
        raw       = diff_w[31:0];
        upd.carry = diff_w[32];
        upd.wrap  = ovf;
      end
      OP_AND:
      begin
        raw          = req.a & req.b;
        upd.carry_we = 1'b0;
      end
      OP_OR:
      begin
        raw          = req.a | req.b;
        upd.carry_we = 1'b0;
      end
      OP_XOR:
      begin
        raw          = req.a ^ req.b;
        upd.carry_we = 1'b0;
      end
      default:
      begin
        raw = sum_w[31:0];
      end
    endcase
    result = raw;
    if ((req.op == OP_CLAMPADD) || (req.op == OP_CLAMPSUB))
    begin
      if (ovf && !req.a[31])
      begin
        result        = CLAMP_MAX;
        upd.clamp_set = 1'b1;
      end
      else if (ovf)
      begin
        result        = CLAMP_MIN;
        upd.clamp_set = 1'b1;
      end
    end
    upd.sign = result[31];
    upd.zero = (result == WORD_ZERO);
  end

endmodule // flag_calc

//--- rtl/psw_flag_logic.sv
`timescale 1ns/10ps
// Summary of operation
// - Taking an exception sets the exception bit
// - Exception bit never masks interrupt acknowledgement
// - Mask bit blocks acks; unblock clears, block sets
// - Clamp flag sticky once set
// - Only a status word write clears clamp flag
// - Plain arithmetic leaves clamp flag alone
// - Carry flag shows carry out or borrow
// - Wrap flag shows signed overflow
// - Sign flag shows negative result
// - Zero flag shows result equal zero
// - Positive clamp: max value, clamp, wrap, sign 0
// - Negative clamp: min value, clamp, wrap, sign 1
// - In range: plain result, wrap 0, clamp held
// - Clamp flag set only with wrap set
module psw_flag_logic
  import psw_flag_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Execution datapath
  input  wire alu_req_t    alu_req,
  output logic [31:0]      result_q,
  output logic             result_valid_q,
  // System register access
  input  wire logic        load_system_reg_instr,
  input  wire logic [31:0] sysreg_wdata,
  output logic [31:0]      sysreg_rdata_q,
  // Interrupt control instructions
  input  wire logic        irq_unblock_instr,
  input  wire logic        irq_block_instr,
  // Exception and interrupt sequencer
  input  wire logic        exc_take,
  input  wire logic        irq_req,
  output logic             irq_ack,
  // Status word view
  output logic [31:0]      program_status_flags
);

  logic [31:0] calc_result;
  flag_upd_t   calc_upd;
  logic        op_fire;
  logic        clamp_op;
  logic        irq_take;

  logic        zero_q;
  logic        sign_q;
  logic        wrap_q;
  logic        carry_q;
  logic        clamp_q;
  logic        mask_q;
  logic        exc_q;
  irq_state_t  irq_state_q;
  irq_state_t  irq_state_d;

  flag_calc u_flag_calc (
    .req    (alu_req),
    .result (calc_result),
    .upd    (calc_upd)
  );

  assign op_fire  = alu_req.valid;
  assign clamp_op = (alu_req.op == OP_CLAMPADD) ||
                    (alu_req.op == OP_CLAMPSUB);

  // Result register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q       <= WORD_ZERO;
      result_valid_q <= 1'b0;
    end
    else
    begin
      result_valid_q <= op_fire && calc_upd.write_back;
      if (op_fire && calc_upd.write_back)
      begin
        result_q <= calc_result;
      end
    end
  end

  // Zero flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_q <= PSW_RESET[ZERO_POS];
    end
    else if (load_system_reg_instr)
    begin
      zero_q <= sysreg_wdata[ZERO_POS];
    end
    else if (op_fire)
    begin
      zero_q <= calc_upd.zero;
    end
  end

  // Sign flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sign_q <= PSW_RESET[SIGN_POS];
    end
    else if (load_system_reg_instr)
    begin
      sign_q <= sysreg_wdata[SIGN_POS];
    end
    else if (op_fire)
    begin
      sign_q <= calc_upd.sign;
    end
  end

  // Signed wrap flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrap_q <= PSW_RESET[WRAP_POS];
    end
    else if (load_system_reg_instr)
    begin
      wrap_q <= sysreg_wdata[WRAP_POS];
    end
    else if (op_fire)
    begin
      wrap_q <= calc_upd.wrap;
    end
  end

  // Carry or borrow flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carry_q <= PSW_RESET[CARRY_POS];
    end
    else if (load_system_reg_instr)
    begin
      carry_q <= sysreg_wdata[CARRY_POS];
    end
    else if (op_fire && calc_upd.carry_we)
    begin
      carry_q <= calc_upd.carry;
    end
  end

  // Sticky clamp flag: set by a clamped result, cleared only by software
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clamp_q <= PSW_RESET[CLAMP_POS];
    end
    else if (load_system_reg_instr)
    begin
      clamp_q <= sysreg_wdata[CLAMP_POS];
    end
    else if (op_fire && clamp_op && calc_upd.clamp_set && calc_upd.wrap)
    begin
      clamp_q <= 1'b1;
    end
    // Other operations hold the flag
  end

  // Interrupt mask bit
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= PSW_RESET[MASK_POS];
    end
    else if (load_system_reg_instr)
    begin
      mask_q <= sysreg_wdata[MASK_POS];
    end
    else if (irq_block_instr || irq_take)
    begin
      mask_q <= 1'b1;
    end
    else if (irq_unblock_instr)
    begin
      mask_q <= 1'b0;
    end
  end

  // Exception in progress: a taken exception beats a same-cycle write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_q <= PSW_RESET[EXC_POS];
    end
    else if (exc_take)
    begin
      exc_q <= 1'b1;
    end
    else if (load_system_reg_instr)
    begin
      exc_q <= sysreg_wdata[EXC_POS];
    end
  end

  // Interrupt acknowledge sequencing
  assign irq_take = (irq_state_q == IRQ_IDLE) && irq_req &&
                    !mask_q;

  always_comb
  begin
    irq_state_d = irq_state_q;
    case (irq_state_q)
      IRQ_IDLE:
      begin
        if (irq_take)
        begin
          irq_state_d = IRQ_ACK;
        end
      end
      IRQ_ACK:
      begin
        irq_state_d = IRQ_HOLD;
      end
      IRQ_HOLD:
      begin
        if (!irq_req)
        begin
          irq_state_d = IRQ_IDLE;
        end
      end
      default:
      begin
        irq_state_d = IRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_state_q <= IRQ_IDLE;
    end
    else
    begin
      irq_state_q <= irq_state_d;
    end
  end

  assign irq_ack = (irq_state_q == IRQ_ACK);

  // Status word view and system register read
  always_comb
  begin
    program_status_flags            = WORD_ZERO;
    program_status_flags[ZERO_POS]  = zero_q;
    program_status_flags[SIGN_POS]  = sign_q;
    program_status_flags[WRAP_POS]  = wrap_q;
    program_status_flags[CARRY_POS] = carry_q;
    program_status_flags[CLAMP_POS] = clamp_q;
    program_status_flags[MASK_POS]  = mask_q;
    program_status_flags[EXC_POS]   = exc_q;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysreg_rdata_q <= PSW_RESET;
    end
    else
    begin
      sysreg_rdata_q <= program_status_flags & PSW_WR_MASK;
    end
  end

endmodule // psw_flag_logic

//--- bench/psw_flag_properties.sv
`timescale 1ns/10ps
module psw_flag_checker
  import psw_flag_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Datapath
  input wire alu_req_t    alu_req,
  input wire logic [31:0] result_q,
  input wire logic        result_valid_q,
  // System register
  input wire logic        load_system_reg_instr,
  input wire logic [31:0] sysreg_wdata,
  input wire logic [31:0] sysreg_rdata_q,
  // Interrupt and exception
  input wire logic        irq_unblock_instr,
  input wire logic        irq_block_instr,
  input wire logic        exc_take,
  input wire logic        irq_req,
  input wire logic        irq_ack,
  input wire logic [31:0] program_status_flags
);
  logic        ld;
  logic        upd_q;
  logic        clamp_q;
  logic [31:0] f;
  assign ld = load_system_reg_instr;
  assign f  = program_status_flags;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Marks a non-compare op whose flags were not overridden by a status write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upd_q   <= 1'b0;
      clamp_q <= 1'b0;
    end
    else
    begin
      upd_q   <= alu_req.valid && !ld && alu_req.op != OP_CMP;
      clamp_q <= alu_req.valid && !ld && alu_req.op[2:1] == 2'b11;
    end
  end
  property p_exc; exc_take |=> f[6]; endproperty
  a_exc: assert property (p_exc) else $error("exc bit");
  property p_ack; irq_ack |-> $past(!f[5]); endproperty
  a_ack: assert property (p_ack) else $error("masked ack");
  property p_blk; irq_block_instr && !ld |=> f[5]; endproperty
  a_blk: assert property (p_blk) else $error("block");
  property p_stk; f[4] && !ld |=> f[4]; endproperty
  a_stk: assert property (p_stk) else $error("sticky");
  // The op sampled at this edge is the one that may set the flag
  property p_hold;
    !f[4] && !ld && !(alu_req.valid && alu_req.op[2:1] == 2'b11) |=> !f[4];
  endproperty
  a_hold: assert property (p_hold) else $error("clamp set");
  property p_zero; upd_q |-> f[0] == (result_q == WORD_ZERO); endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_sign; upd_q |-> f[1] == result_q[31]; endproperty
  a_sign: assert property (p_sign) else $error("sign");
  property p_clmp;
    clamp_q && f[2] |->
      f[4] && (result_q == CLAMP_MAX || result_q == CLAMP_MIN);
  endproperty
  a_clmp: assert property (p_clmp) else $error("clamp");
  property p_only; $rose(f[4]) && !$past(ld) |-> f[2]; endproperty
  a_only: assert property (p_only) else $error("clamp no wrap");
  property p_ld; ld |=> f[5:0] == $past(sysreg_wdata[5:0]); endproperty
  a_ld: assert property (p_ld) else $error("load");
  c_ack: cover property (irq_ack && f[6]);
  c_clmp: cover property (clamp_q && f[2]);
  c_ld: cover property (ld && alu_req.valid);
endmodule // psw_flag_checker

bind psw_flag_logic psw_flag_checker u_chk (
  .core_clk, .rst_n, .alu_req, .result_q, .result_valid_q,
  .load_system_reg_instr, .sysreg_wdata, .sysreg_rdata_q,
  .irq_unblock_instr, .irq_block_instr, .exc_take, .irq_req, .irq_ack,
  .program_status_flags
);

//--- bench/processor_status_flag_logic_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module processor_status_flag_logic_tb_top
  import psw_flag_pkg::*;
;
  typedef struct packed {
    alu_op_t     op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [4:0]  f;
  } row_t;
  logic        core_clk;
  logic        rst_n;
  alu_req_t    alu_req;
  logic [31:0] result_q;
  logic        result_valid_q;
  logic        load_system_reg_instr;
  logic [31:0] sysreg_wdata;
  logic [31:0] sysreg_rdata_q;
  logic        irq_unblock_instr;
  logic        irq_block_instr;
  logic        exc_take;
  logic        irq_req;
  logic        irq_ack;
  logic [31:0] program_status_flags;
  int          errors;
  int          comparisons;
  // Flags column: clamp, carry, wrap, sign, zero
  row_t rows [11] = '{
    '{OP_ADD, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0000, 5'h09},
    '{OP_ADD, 32'h7FFF_FFFF, 32'h0000_0001, 32'h8000_0000, 5'h06},
    '{OP_SUB, 32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF, 5'h0A},
    '{OP_AND, 32'h0000_00F0, 32'h0000_000F, 32'h0000_0000, 5'h09},
    '{OP_XOR, 32'h8000_0000, 32'h0000_0000, 32'h8000_0000, 5'h0A},
    '{OP_OR, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 5'h09},
    '{OP_CLAMPADD, 32'h7FFF_FFFF, 32'h0000_0001, 32'h7FFF_FFFF, 5'h14},
    '{OP_CLAMPSUB, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000, 5'h16},
    '{OP_CLAMPADD, 32'h0000_0001, 32'h0000_0002, 32'h0000_0003, 5'h10},
    '{OP_ADD, 32'h0000_0005, 32'h0000_0005, 32'h0000_000A, 5'h10},
    '{OP_CMP, 32'h0000_0003, 32'h0000_0003, 32'h0000_000A, 5'h11}
  };

  psw_flag_logic u_dut (
    .core_clk, .rst_n, .alu_req, .result_q, .result_valid_q,
    .load_system_reg_instr, .sysreg_wdata, .sysreg_rdata_q,
    .irq_unblock_instr, .irq_block_instr, .exc_take, .irq_req, .irq_ack,
    .program_status_flags
  );

  task final_report;
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    #20000;
    errors++;
    final_report;
  end

  initial
  begin
    errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    alu_req = '0;
    load_system_reg_instr = 1'b0;
    sysreg_wdata = '0;
    irq_unblock_instr = 1'b0;
    irq_block_instr = 1'b0;
    exc_take = 1'b0;
    irq_req = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    `CHK(program_status_flags, 32'h0000_0020)
    foreach (rows[i])
    begin
      alu_req = '{1'b1, rows[i].op, rows[i].a, rows[i].b};
      @(negedge core_clk);
      `CHK(result_q, rows[i].r)
      `CHK(program_status_flags[4:0], rows[i].f)
      `CHK(result_valid_q, rows[i].op != OP_CMP)
    end
    // Status write against a same-cycle clamping overflow
    alu_req = '{1'b1, OP_CLAMPADD, 32'h7FFF_FFFF, 32'h0000_0001};
    load_system_reg_instr = 1'b1;
    sysreg_wdata = 32'hFFFF_FF80;
    @(negedge core_clk);
    alu_req.valid = 1'b0;
    load_system_reg_instr = 1'b0;
    `CHK(program_status_flags, 32'h0000_0000)
    `CHK(result_q, 32'h7FFF_FFFF)
    `CHK(result_valid_q, 1'b1)
    exc_take = 1'b1;
    @(negedge core_clk);
    exc_take = 1'b0;
    `CHK(program_status_flags[6], 1'b1)
    `CHK(result_valid_q, 1'b0)
    irq_req = 1'b1;
    @(negedge core_clk);
    `CHK(irq_ack, 1'b1)
    `CHK(program_status_flags[5], 1'b1)
    irq_req = 1'b0;
    repeat (2) @(negedge core_clk);
    irq_req = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(irq_ack, 1'b0)
    irq_unblock_instr = 1'b1;
    @(negedge core_clk);
    irq_unblock_instr = 1'b0;
    `CHK(program_status_flags[5], 1'b0)
    @(negedge core_clk);
    `CHK(irq_ack, 1'b1)
    irq_req = 1'b0;
    irq_unblock_instr = 1'b1;
    @(negedge core_clk);
    irq_unblock_instr = 1'b0;
    irq_block_instr = 1'b1;
    @(negedge core_clk);
    irq_block_instr = 1'b0;
    `CHK(program_status_flags[5], 1'b1)
    @(negedge core_clk);
    `CHK(sysreg_rdata_q, 32'h0000_0060)
    // Reset in mid-run returns every output to its idle value
    alu_req = '{1'b1, OP_ADD, 32'h0000_0001, 32'h0000_0001};
    @(negedge core_clk);
    rst_n = 1'b0;
    alu_req.valid = 1'b0;
    @(negedge core_clk);
    `CHK(program_status_flags, 32'h0000_0020)
    `CHK(result_q, 32'h0000_0000)
    `CHK(result_valid_q, 1'b0)
    `CHK(sysreg_rdata_q, 32'h0000_0020)
    `CHK(irq_ack, 1'b0)
    rst_n = 1'b1;
    alu_req = '{1'b1, OP_SUB, 32'h0000_0002, 32'h0000_0002};
    @(negedge core_clk);
    alu_req.valid = 1'b0;
    `CHK(program_status_flags, 32'h0000_0021)
    `CHK(result_valid_q, 1'b1)
    @(negedge core_clk);
    `CHK(result_valid_q, 1'b0)
    final_report;
  end
endmodule // processor_status_flag_logic_tb_top
